// *** tb/result_format_assertions.sv ***
`timescale 1ns/10ps
module result_format_assertions (
  // Design ports.
  input wire clk_i,
  input wire rst_i,
  input wire [15:0] primary_config_register_i,
  input wire conv_ready_o,
  input wire conv_start_o,
  input wire cs_n_i,
  input wire sclk_i,
  input wire sdo_a_o,
  input wire sdo_b_o,
  input wire sdo_oe_o,
  input wire wide_result_o
);
  wire [15:0] c = primary_config_register_i;
  wire boost = c[9] && c[2] && c[8:6] != 3'h0 && !c[8];
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  one_start_a: assert property (conv_start_o |=> !conv_start_o) else $error("start");
  fall_start_a: assert property ($fell(cs_n_i) |-> ##[1:6] conv_start_o) else $error("no start");
  idle_start_a: assert property (cs_n_i [*5] |-> !conv_start_o) else $error("idle start");
  width_sel_a: assert property (!$past(rst_i) |-> wide_result_o == $past(boost)) else $error("width");
  idle_oe_a: assert property (cs_n_i [*5] |-> !sdo_oe_o) else $error("idle oe");
  sel_oe_a: assert property ((!cs_n_i) [*5] |-> sdo_oe_o) else $error("no oe");
  sdo_hold_a: assert property (sclk_i [*4] |-> $stable({sdo_a_o, sdo_b_o})) else $error("sdo");
  ready_rel_a: assert property ($fell(rst_i) |=> conv_ready_o) else $error("ready");
endmodule // result_format_assertions
bind result_format result_format_assertions i_result_format_assertions (.*);

// *** tb/result_format_tb.sv ***
`timescale 1ns/10ps
module result_format_tb;
  logic clk_i, rst_i, conv_valid_i, conv_ready_o, conv_start_o, cs_n_i, sclk_i, sdo_a_o;
  logic sdo_b_o, sdo_oe_o, wide_result_o;
  logic [15:0] primary_config_register_i;
  logic [31:0] conv_data_i, w, pq[$];
  logic [36:0] e, eq[$];
  int h[2][$];
  int checks, miscompares, r, s, seed = 61;
  result_format i_result_format (.*);
  // A deselected output shows the inverse of its last bit, so a late enable is seen.
  spi_host_model i_spi_host_model (.cs_n_o(cs_n_i), .sclk_o(sclk_i),
    .sdo_a_i(sdo_oe_o ? sdo_a_o : ~sdo_a_o), .sdo_b_i(sdo_oe_o ? sdo_b_o : ~sdo_b_o));
  task check(input logic [36:0] g, x);
    checks++;
    if (g !== x) begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, g, x);
    end
  endtask
  task results;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task push;
    @(posedge clk_i);
    conv_data_i <= $random(seed);
    conv_valid_i <= 1'b1;
    do @(posedge clk_i); while (conv_ready_o !== 1'b1);
    pq.push_back(conv_data_i);
    conv_valid_i <= 1'b0;
  endtask
  task run(input logic [15:0] c);
    @(posedge clk_i);
    primary_config_register_i <= c;
    r = c[9] && c[8:6] < 3'h4 ? c[8:6] : 0;
    e[36] = r > 0 && c[2];
    if (pq.size() > 0) begin
      w = pq.pop_front();
      h[0].push_front($signed(w[31:16]));
      h[1].push_front($signed(w[15:0]));
    end
    for (int k = 0; k < 2; k++) begin
      s = 0;
      for (int j = 0; j < 1 << r; j++) s += h[k][j];
      s = e[36] ? s * 4 >>> r : (s >>> r) * 4;
      e[35 - 18 * k -: 18] = s[17:0];
    end
    eq.push_back(e);
    i_spi_host_model.frame();
  endtask
  always @(i_spi_host_model.done)
    check({wide_result_o, i_spi_host_model.got}, eq.pop_front());
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  initial #500000 begin
    miscompares++;
    results();
  end
  initial begin
    {rst_i, conv_valid_i, conv_data_i, primary_config_register_i} = 50'h2000000000000;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (16) push();
    @(posedge clk_i);
    conv_valid_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    check(conv_ready_o, 1'b0);
    conv_valid_i <= 1'b0;
    // Frame 16 finds the buffer empty, so the history must stay as it was.
    for (int k = 0; k < 32; k++) begin
      if (k > 16) push();
      run({6'h00, k[0], k[3:1], 3'h0, k[4], 2'h0});
    end
    results();
  end
endmodule // result_format_tb

// *** tb/spi_host_model.sv ***
`timescale 1ns/10ps
module spi_host_model (
  // Serial pins.
  output logic cs_n_o = 1'b1,
  output logic sclk_o = 1'b0,
  input wire sdo_a_i,
  input wire sdo_b_i
);
  logic [35:0] got;
  event done;
  // Eighteen clocks always, so a 16-bit result must show two zero bits.
  task frame;
    #7 cs_n_o = 1'b0;
    #1013;
    repeat (18) begin
      sclk_o = 1'b1;
      got = {got[34:18], sdo_a_i, got[16:0], sdo_b_i};
      #160 sclk_o = 1'b0;
      #160;
    end
    cs_n_o = 1'b1;
    -> done;
    #997;
  endtask
endmodule // spi_host_model

// *** verilog/result_format.v ***
`timescale 1ns/10ps
`include "result_format_regs.vh"

module sample_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Fill side
  input wire [WIDTH-1:0] in_data_i,
  input wire in_valid_i,
  output reg in_ready_o,
  // Drain side
  output wire [WIDTH-1:0] out_data_o,
  output wire out_valid_o,
  input wire out_ready_i
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] count_reg;
  reg [AW:0] count_next;

  wire push;
  wire pop;

  // The pointers simply wrap, so the depth must be a power of two.
  assign out_valid_o = (count_reg != {(AW+1){1'b0}});
  assign out_data_o = mem[rd_ptr_reg];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always @* begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
  end

  // Ready is registered, so a full buffer stalls the source from the next edge on.
  always @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
      in_ready_o <= 1'b0;
    end else begin
      count_reg <= count_next;
      in_ready_o <= (count_next < DEPTH);
      if (push) begin
        mem[wr_ptr_reg] <= in_data_i;
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end
endmodule // sample_fifo

module result_format #(
  parameter DW = `BASE_WIDTH,
  parameter HD = `HIST_DEPTH,
  parameter FD = `FIFO_DEPTH
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Configuration
  input wire [`CFG_WIDTH-1:0] primary_config_register_i,
  // Conversion core, channel A in the upper half
  input wire [2*DW-1:0] conv_data_i,
  input wire conv_valid_i,
  output wire conv_ready_o,
  output reg conv_start_o,
  // Serial pins
  input wire cs_n_i,
  input wire sclk_i,
  output reg sdo_a_o,
  output reg sdo_b_o,
  output reg sdo_oe_o,
  output reg wide_result_o
);
  localparam FIFO_AW = $clog2(FD);

  // Two stages settle each pin; the third only serves to find its edges.
  reg cs_s1_reg, cs_s2_reg, cs_s3_reg;
  reg ck_s1_reg, ck_s2_reg, ck_s3_reg;
  reg load_pend_reg;
  reg [DW*HD-1:0] hist_a_reg;
  reg [DW*HD-1:0] hist_b_reg;
  reg [`BOOST_WIDTH-1:0] sh_a_reg;
  reg [`BOOST_WIDTH-1:0] sh_b_reg;

  wire [2*DW-1:0] fifo_data;
  wire fifo_valid;
  wire cs_fall;
  wire sclk_fall;
  wire pop;

  wire avg_en;
  wire [2:0] ratio;
  wire valid_os;
  wire boost;
  wire [2:0] ratio_eff;
  wire [`BOOST_WIDTH-1:0] word_a;
  wire [`BOOST_WIDTH-1:0] word_b;

  // Averages the newest 2^r entries and left-aligns the word in 18 bits.
  function [`BOOST_WIDTH-1:0] avg_word;
    input [DW*HD-1:0] h;
    input [2:0] r;
    input wide;
    integer i;
    reg signed [DW+3:0] s;
    reg signed [DW+5:0] t;
    begin
      s = {(DW+4){1'b0}};
      t = {(DW+6){1'b0}};
      for (i = 0; i < HD; i = i + 1) begin
        if (i < (1 << r)) begin
          s = s + {{4{h[i*DW+DW-1]}}, h[i*DW +: DW]};
        end
      end
      if (r == 3'h0) begin
        avg_word = {h[DW-1:0], 2'b00}; // R11
      end else if (wide) begin
        t = {s, 2'b00} >>> r; // R2
        avg_word = t[`BOOST_WIDTH-1:0];
      end else begin
        t = {{2{s[DW+3]}}, s} >>> r;
        avg_word = {t[DW-1:0], 2'b00};
      end
    end
  endfunction

  assign avg_en = primary_config_register_i[`AVG_EN_BIT];
  assign ratio = primary_config_register_i[`RATIO_HI:`RATIO_LO];
  // Ratio codes above eight samples are treated as invalid, like a zero ratio.
  assign valid_os = avg_en & (ratio != 3'h0) & (ratio <= `RATIO_MAX); // R4
  assign ratio_eff = valid_os ? ratio : 3'h0; // R5
  assign boost = valid_os & primary_config_register_i[`EXTRA_BITS_BIT]; // R9
  assign word_a = avg_word(hist_a_reg, ratio_eff, boost);
  assign word_b = avg_word(hist_b_reg, ratio_eff, boost);

  // The second and third synchroniser stages feed the edge detectors.
  assign cs_fall = cs_s3_reg & ~cs_s2_reg;
  assign sclk_fall = ck_s3_reg & ~ck_s2_reg & ~cs_s2_reg;
  assign pop = cs_fall & fifo_valid;

  // Results that the host has not yet fetched wait here; a full buffer stalls the core.
  sample_fifo #(
    .WIDTH(2*DW),
    .DEPTH(FD),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_data_i(conv_data_i),
    .in_valid_i(conv_valid_i),
    .in_ready_o(conv_ready_o),
    .out_data_o(fifo_data),
    .out_valid_o(fifo_valid),
    .out_ready_i(cs_fall)
  );

  always @(posedge clk_i) begin
    if (rst_i) begin
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
      cs_s3_reg <= 1'b1;
      ck_s1_reg <= 1'b0;
      ck_s2_reg <= 1'b0;
      ck_s3_reg <= 1'b0;
      load_pend_reg <= 1'b0;
      conv_start_o <= 1'b0;
      hist_a_reg <= {(DW*HD){1'b0}};
      hist_b_reg <= {(DW*HD){1'b0}};
      sh_a_reg <= {`BOOST_WIDTH{1'b0}};
      sh_b_reg <= {`BOOST_WIDTH{1'b0}};
      sdo_a_o <= 1'b0;
      sdo_b_o <= 1'b0;
      sdo_oe_o <= 1'b0;
      wide_result_o <= 1'b0;
    end else begin
      cs_s1_reg <= cs_n_i;
      cs_s2_reg <= cs_s1_reg;
      cs_s3_reg <= cs_s2_reg;
      ck_s1_reg <= sclk_i;
      ck_s2_reg <= ck_s1_reg;
      ck_s3_reg <= ck_s2_reg;

      conv_start_o <= cs_fall; // R8
      load_pend_reg <= cs_fall;
      sdo_oe_o <= ~cs_s2_reg;
      wide_result_o <= boost; // R3

      // The history keeps shifting whatever the ratio, so a mode change needs no refill.
      // A frame that finds the buffer empty leaves it alone, so the result is formed again from the same history.
      if (pop) begin
        hist_a_reg <= {hist_a_reg[DW*(HD-1)-1:0], fifo_data[2*DW-1:DW]};
        hist_b_reg <= {hist_b_reg[DW*(HD-1)-1:0], fifo_data[DW-1:0]};
      end

      // The word is held left aligned in 18 bits, so a 16-bit result trails two zeros.
      if (load_pend_reg) begin
        sh_a_reg <= word_a; // R1
        sh_b_reg <= word_b;
        sdo_a_o <= word_a[`BOOST_WIDTH-1];
        sdo_b_o <= word_b[`BOOST_WIDTH-1];
      end else if (sclk_fall) begin
        sh_a_reg <= {sh_a_reg[`BOOST_WIDTH-2:0], 1'b0}; // R1
        sh_b_reg <= {sh_b_reg[`BOOST_WIDTH-2:0], 1'b0};
        sdo_a_o <= sh_a_reg[`BOOST_WIDTH-2];
        sdo_b_o <= sh_b_reg[`BOOST_WIDTH-2];
      end
    end
  end
endmodule // result_format

// *** verilog/result_format_regs.vh ***
// Contract
// (R1) Results leave as twos complement, most significant bit first, least significant last.
// (R2) One code step equals reference divided by two to the active width.
// (R3) Width is 16 bits normally, 18 bits with resolution boost.
// (R4) Averaging runs only with enable bit 9 set and ratio bits 8:6 nonzero.
// (R5) Enable bit and ratio both zero give unaveraged results.
// (R6) Host holds select high through the supply settle interval after power-up.
// (R7) Host should issue a software reset after power-up completes.
// (R8) Every falling edge of chip select starts a conversion.
// (R9) 18-bit width needs extra bits enable and a valid averaging mode.
// (R10) Host gives 18 serial clocks per result when 18-bit width is active.
// (R11) Without a valid averaging setting, the newest single result is output.
`ifndef RESULT_FORMAT_REGS_VH
`define RESULT_FORMAT_REGS_VH
`define CFG_WIDTH 16
`define AVG_EN_BIT 9
`define RATIO_HI 8
`define RATIO_LO 6
`define EXTRA_BITS_BIT 2
`define RATIO_MAX 3'h3
`define BASE_WIDTH 16
`define BOOST_WIDTH 18
`define HIST_DEPTH 8
`define FIFO_DEPTH 16
`endif
